// *** inc/sudc_pkg.sv ***
// Shared constants and types for the up/down counter stage and its controller
package sudc_pkg;
	localparam int COUNT_WIDTH = 12;
	localparam int DIGIT_WIDTH = 4;
	localparam int BCD_DIGITS = 3;
	localparam logic [11:0] BIN_MAX = 12'hFFF;
	localparam logic [11:0] BCD_MAX = 12'h999;
	localparam logic [11:0] COUNT_MIN = 12'h000;
	localparam logic [11:0] BIN_ONE = 12'h001;
	localparam logic [3:0] DIGIT_NINE = 4'h9;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;
	localparam logic [3:0] DIGIT_ONE = 4'h1;

	localparam int CLK_PERIOD_NS = 10;
	localparam int MIN_LOW_NS = 50;
	localparam int MIN_HIGH_NS = 50;
	localparam int MIN_LOAD_NS = 50;
	localparam int DIR_GUARD_NS = 40;
	localparam int MIN_LOW_CYC = (MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_HIGH_CYC = (MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_LOAD_CYC = (MIN_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIR_GUARD_CYC = (DIR_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_HIGH_CYC = (MIN_HIGH_CYC > DIR_GUARD_CYC) ? MIN_HIGH_CYC : DIR_GUARD_CYC + 1;
	localparam int TIMER_WIDTH = 8;

	localparam int WB_ADDR_WIDTH = 8;
	localparam int WB_DATA_WIDTH = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LOAD = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
	localparam logic [7:0] REG_IRQ_MASK = 8'h14;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_DOWN_BIT = 1;
	localparam int CTRL_RELOAD_BIT = 2;
	localparam int STAT_MAXMIN_BIT = 12;
	localparam int STAT_BUSY_BIT = 13;
	localparam int IRQ_WIDTH = 2;
	localparam int IRQ_TERM_BIT = 0;
	localparam int IRQ_DONE_BIT = 1;
	localparam int PULSE_CNT_WIDTH = 16;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HIGH = 4'h2,
		ST_LOW = 4'h4,
		ST_LOAD = 4'h8
	} sudc_ctl_state_t;
endpackage : sudc_pkg

// *** inc/sudc_link_if.sv ***
// Link between the counter stage and the logic that drives it
interface sudc_link_if;
	import sudc_pkg::*;
	logic countIn;
	logic enable;
	logic loadN;
	logic [COUNT_WIDTH-1:0] loadData;
	logic downDir;
	logic [COUNT_WIDTH-1:0] count;
	logic carryOut;
	logic maxMin;

	modport dev (
		input countIn,
		input enable,
		input loadN,
		input loadData,
		input downDir,
		output count,
		output carryOut,
		output maxMin
	);

	modport ctl (
		output countIn,
		output enable,
		output loadN,
		output loadData,
		output downDir,
		input count,
		input carryOut,
		input maxMin
	);
endinterface : sudc_link_if

// *** hdl/sudc_counter.sv ***
// Synchronous up/down counter stage, binary or three-digit BCD
// Functional notes
// - Count only on rising count pulse edge
// - Count only while enable is high
// - Low load forces data into every bit
// - Load is a level; later data ignored
// - Direction low counts up, high down
// - Direction change leaves stored count untouched
// - Direction changes only while count pulse high
// - Binary terminals are all ones, all zeros
// - BCD terminals are 999 and 000
// - At terminal, carry follows the count pulse
// - Terminal flag high exactly at terminal state
// - Carry drives next stage count pulse input
// - Terminal flag may enable next stage
// - Modulo N: reload N at zero down
// - Binary count is 12 bits, all synchronous
module sudc_counter #(
	parameter bit BCD_MODE = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	sudc_link_if.dev link,
	output logic wrapPulse,
	output logic timingFault
);
	import sudc_pkg::*;

	logic countPrev;
	logic dirPrev;
	logic loadPrev;
	logic countEdge;
	logic countStep;
	logic [COUNT_WIDTH-1:0] binStepped;
	logic [COUNT_WIDTH-1:0] bcdStepped;
	logic [COUNT_WIDTH-1:0] stepped;
	logic [COUNT_WIDTH-1:0] next_count;
	logic [BCD_DIGITS:0] ripple;
	logic [TIMER_WIDTH-1:0] lowTime;
	logic [TIMER_WIDTH-1:0] loadTime;
	logic shortLow;
	logic shortLoad;
	logic dirSlip;

	if (COUNT_WIDTH != BCD_DIGITS * DIGIT_WIDTH)
	begin : gWidthCheck
		$error("Count width does not match the BCD digit layout");
	end

	if (PULSE_HIGH_CYC < 1 || MIN_LOW_CYC >= (1 << TIMER_WIDTH))
	begin : gTimerCheck
		$error("Timing counts do not fit the phase timers");
	end

	// The load timer shares the phase timer width
	if (MIN_LOAD_CYC < 1 || MIN_LOAD_CYC >= (1 << TIMER_WIDTH))
	begin : gLoadCheck
		$error("Load time does not fit the load timer");
	end

	function automatic logic [COUNT_WIDTH-1:0] termValue(
		input logic down
	);
		if (down)
			termValue = COUNT_MIN;
		else if (BCD_MODE)
			termValue = BCD_MAX;
		else
			termValue = BIN_MAX;
	endfunction : termValue

	function automatic logic atTerminal(
		input logic [COUNT_WIDTH-1:0] value,
		input logic down
	);
		atTerminal = (value == termValue(down));
	endfunction : atTerminal

	// Pulse input comes from logic on this same clock, so no synchroniser
	assign countEdge = link.countIn & ~countPrev;
	assign countStep = countEdge & link.enable;

	// Binary step wraps naturally at the width
	assign binStepped = link.downDir ? COUNT_WIDTH'(link.count - BIN_ONE) : COUNT_WIDTH'(link.count + BIN_ONE);

	// Per-digit decade step with a ripple chain across the digits
	assign ripple[0] = 1'b1;
	for (genvar i = 0; i < BCD_DIGITS; i++)
	begin : gDigit
		logic [DIGIT_WIDTH-1:0] digit;
		logic atLimit;
		assign digit = link.count[i*DIGIT_WIDTH +: DIGIT_WIDTH];
		// A digit above nine after a load is treated as at its upper limit
		assign atLimit = link.downDir ? (digit == DIGIT_ZERO) : (digit >= DIGIT_NINE);
		assign ripple[i+1] = ripple[i] & atLimit;
		assign bcdStepped[i*DIGIT_WIDTH +: DIGIT_WIDTH] = !ripple[i] ? digit :
			atLimit ? (link.downDir ? DIGIT_NINE : DIGIT_ZERO) :
			link.downDir ? DIGIT_WIDTH'(digit - DIGIT_ONE) : DIGIT_WIDTH'(digit + DIGIT_ONE);
	end

	assign stepped = BCD_MODE ? bcdStepped : binStepped;

	always_comb
	begin
		next_count = link.count;
		if (!link.loadN)
			next_count = link.loadData;
		else if (countStep)
			next_count = stepped;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			link.count <= COUNT_MIN;
		else
			link.count <= next_count;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			countPrev <= 1'b1;
		else
			countPrev <= link.countIn;
	end

	// Flag tracks the direction too, so it moves when the direction flips
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			link.maxMin <= 1'b0;
		else
			link.maxMin <= atTerminal(next_count, link.downDir);
	end

	// Gated with the flag before the step, so a wrap edge passes one carry pulse
	// It also rises when a terminal is reached with the pulse still high, so a
	// stage clocked from this carry steps early; look-ahead cascading avoids that
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			link.carryOut <= 1'b0;
		else
			link.carryOut <= link.maxMin & link.countIn;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			wrapPulse <= 1'b0;
		else
			// Marks a step taken from a terminal, for logic that counts wraps
			wrapPulse <= countStep & link.loadN & link.maxMin;
	end

	// Saturating width counters for the pulse low phase and the load level
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			lowTime <= '0;
		else if (link.countIn)
			lowTime <= '0;
		else if (lowTime < TIMER_WIDTH'(MIN_LOW_CYC))
			lowTime <= TIMER_WIDTH'(lowTime + 1'b1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			loadTime <= '0;
		else if (link.loadN)
			loadTime <= '0;
		else if (loadTime < TIMER_WIDTH'(MIN_LOAD_CYC))
			loadTime <= TIMER_WIDTH'(loadTime + 1'b1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dirPrev <= 1'b0;
			loadPrev <= 1'b1;
		end
		else
		begin
			dirPrev <= link.downDir;
			loadPrev <= link.loadN;
		end
	end

	assign shortLow = countEdge & (lowTime < TIMER_WIDTH'(MIN_LOW_CYC));
	assign shortLoad = link.loadN & ~loadPrev & (loadTime < TIMER_WIDTH'(MIN_LOAD_CYC));
	// Direction moving while the pulse is low may corrupt a real stage
	assign dirSlip = (link.downDir != dirPrev) & ~link.countIn & ~countPrev;

	// Sticky until reset; the count itself still behaves as described
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			timingFault <= 1'b0;
		else if (shortLow || shortLoad || dirSlip)
			timingFault <= 1'b1;
	end
endmodule : sudc_counter

// *** hdl/sudc_controller.sv ***
// Wishbone-controlled driver for the counter stage link
//
// The placing of the registers and the Wishbone register port were decided locally.
module sudc_controller (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [sudc_pkg::WB_ADDR_WIDTH-1:0] adr_i,
	input wire logic [sudc_pkg::WB_DATA_WIDTH-1:0] dat_i,
	output logic [sudc_pkg::WB_DATA_WIDTH-1:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	output logic irq,
	sudc_link_if.ctl link
);
	import sudc_pkg::*;

	sudc_ctl_state_t state;
	logic ctrlEnable;
	logic ctrlDown;
	logic ctrlReload;
	logic [COUNT_WIDTH-1:0] loadValue;
	logic [PULSE_CNT_WIDTH-1:0] pulsesLeft;
	logic [TIMER_WIDTH-1:0] phaseTimer;
	logic [IRQ_WIDTH-1:0] irqStatus;
	logic [IRQ_WIDTH-1:0] irqMask;
	logic [IRQ_WIDTH-1:0] irqEvents;
	logic [WB_DATA_WIDTH-1:0] readData;
	logic [WB_DATA_WIDTH-1:0] merged;
	logic loadPending;
	logic pulsed;
	logic maxPrev;
	logic busWrite;
	logic phaseEnd;
	logic burstDone;

	function automatic logic [WB_DATA_WIDTH-1:0] mergeBytes(
		input logic [WB_DATA_WIDTH-1:0] old,
		input logic [WB_DATA_WIDTH-1:0] data,
		input logic [3:0] sel
	);
		logic [WB_DATA_WIDTH-1:0] mask;
		mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		mergeBytes = (old & ~mask) | (data & mask);
	endfunction : mergeBytes

	// Write lands on the edge where the master sees ack
	assign busWrite = cyc_i & stb_i & we_i & ack_o;
	assign phaseEnd = (phaseTimer <= TIMER_WIDTH'(1));
	assign burstDone = (state == ST_HIGH) & phaseEnd & (pulsesLeft == '0) &
		~(ctrlReload & link.downDir & link.maxMin & pulsed);

	always_comb
	begin
		case (adr_i)
			REG_CTRL: readData = WB_DATA_WIDTH'({ctrlReload, ctrlDown, ctrlEnable});
			REG_LOAD: readData = WB_DATA_WIDTH'(loadValue);
			REG_CMD: readData = WB_DATA_WIDTH'(pulsesLeft);
			REG_STATUS: readData = WB_DATA_WIDTH'({state != ST_IDLE, link.maxMin, link.count});
			REG_IRQ_STATUS: readData = WB_DATA_WIDTH'(irqStatus);
			REG_IRQ_MASK: readData = WB_DATA_WIDTH'(irqMask);
			default: readData = '0;
		endcase
		merged = mergeBytes(readData, dat_i, sel_i);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end
		else
		begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			dat_o <= readData;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrlEnable <= 1'b0;
			ctrlDown <= 1'b0;
			ctrlReload <= 1'b0;
			loadValue <= COUNT_MIN;
			irqMask <= '0;
		end
		else if (busWrite)
		begin
			if (adr_i == REG_CTRL)
			begin
				ctrlEnable <= merged[CTRL_ENABLE_BIT];
				ctrlDown <= merged[CTRL_DOWN_BIT];
				ctrlReload <= merged[CTRL_RELOAD_BIT];
			end
			if (adr_i == REG_LOAD)
				loadValue <= merged[COUNT_WIDTH-1:0];
			if (adr_i == REG_IRQ_MASK)
				irqMask <= merged[IRQ_WIDTH-1:0];
		end
	end

	// A new load request beats the sequencer's clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			loadPending <= 1'b0;
		else if (busWrite && adr_i == REG_LOAD)
			loadPending <= 1'b1;
		else if (state == ST_IDLE)
			loadPending <= 1'b0;
	end

	// Direction and enable move only at rest, with the pulse line high
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			link.enable <= 1'b0;
			link.downDir <= 1'b0;
			link.loadData <= COUNT_MIN;
		end
		else if (state == ST_IDLE)
		begin
			link.enable <= ctrlEnable;
			link.downDir <= ctrlDown;
			link.loadData <= loadValue;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			phaseTimer <= '0;
			pulsesLeft <= '0;
			pulsed <= 1'b0;
			link.countIn <= 1'b1;
			link.loadN <= 1'b1;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (loadPending)
					begin
						state <= ST_LOAD;
						link.loadN <= 1'b0;
						phaseTimer <= TIMER_WIDTH'(MIN_LOAD_CYC);
					end
					else if (pulsesLeft != '0)
					begin
						// Opening high phase keeps the settled direction ahead of the fall
						state <= ST_HIGH;
						phaseTimer <= TIMER_WIDTH'(PULSE_HIGH_CYC);
					end
					else if (busWrite && adr_i == REG_CMD)
						pulsesLeft <= merged[PULSE_CNT_WIDTH-1:0];
				end
				ST_HIGH:
				begin
					if (!phaseEnd)
						phaseTimer <= TIMER_WIDTH'(phaseTimer - 1'b1);
					else if (ctrlReload && link.downDir && link.maxMin && pulsed)
					begin
						state <= ST_LOAD;
						link.loadN <= 1'b0;
						phaseTimer <= TIMER_WIDTH'(MIN_LOAD_CYC);
					end
					else if (pulsesLeft != '0)
					begin
						state <= ST_LOW;
						link.countIn <= 1'b0;
						phaseTimer <= TIMER_WIDTH'(MIN_LOW_CYC);
					end
					else
						state <= ST_IDLE;
				end
				ST_LOW:
				begin
					if (!phaseEnd)
						phaseTimer <= TIMER_WIDTH'(phaseTimer - 1'b1);
					else
					begin
						state <= ST_HIGH;
						link.countIn <= 1'b1;
						pulsesLeft <= PULSE_CNT_WIDTH'(pulsesLeft - 1'b1);
						pulsed <= 1'b1;
						phaseTimer <= TIMER_WIDTH'(PULSE_HIGH_CYC);
					end
				end
				ST_LOAD:
				begin
					if (!phaseEnd)
						phaseTimer <= TIMER_WIDTH'(phaseTimer - 1'b1);
					else
					begin
						state <= ST_HIGH;
						link.loadN <= 1'b1;
						pulsed <= 1'b0;
						phaseTimer <= TIMER_WIDTH'(PULSE_HIGH_CYC);
					end
				end
				default:
				begin
					state <= ST_IDLE;
					link.countIn <= 1'b1;
					link.loadN <= 1'b1;
				end
			endcase
		end
	end

	always_comb
	begin
		irqEvents = '0;
		irqEvents[IRQ_TERM_BIT] = link.maxMin & ~maxPrev;
		irqEvents[IRQ_DONE_BIT] = burstDone;
	end

	// Events win over a write-one clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			maxPrev <= 1'b0;
			irqStatus <= '0;
			irq <= 1'b0;
		end
		else
		begin
			maxPrev <= link.maxMin;
			if (busWrite && adr_i == REG_IRQ_STATUS)
				irqStatus <= (irqStatus & ~IRQ_WIDTH'(mergeBytes('0, dat_i, sel_i))) | irqEvents;
			else
				irqStatus <= irqStatus | irqEvents;
			irq <= |(irqStatus & irqMask);
		end
	end
endmodule : sudc_controller

// *** bench/sudc_link_chk.sv ***
// Assertions on the link between the controller and the binary stage
module sudc_link_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic countIn,
	input wire logic enable,
	input wire logic loadN,
	input wire logic [sudc_pkg::COUNT_WIDTH-1:0] loadData,
	input wire logic downDir,
	input wire logic [sudc_pkg::COUNT_WIDTH-1:0] count,
	input wire logic carryOut,
	input wire logic maxMin
);
	import sudc_pkg::*;
	logic atTerm;
	logic go;
	assign atTerm = downDir ? (count == COUNT_MIN) : (count == BIN_MAX);
	assign go = countIn && enable && loadN;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence lowPhase;
		!countIn [*5] ##1 countIn;
	endsequence
	sequence loadPhase;
		!loadN [*5] ##1 loadN;
	endsequence
	chk_step_up: assert property ($rose(countIn) && go && !downDir
		|=> count == $past(count) + BIN_ONE) else $error("count did not step up");
	chk_step_down: assert property ($rose(countIn) && go && downDir
		|=> count == $past(count) - BIN_ONE) else $error("count did not step down");
	chk_count_hold: assert property (loadN && !($rose(countIn) && go)
		|=> $stable(count)) else $error("count moved without a step");
	chk_load_force: assert property (!loadN |=> count == $past(loadData))
		else $error("load did not force the count");
	chk_term_flag: assert property ($stable(atTerm) |-> maxMin == atTerm)
		else $error("terminal flag wrong");
	chk_carry_follow: assert property ($stable(maxMin && countIn) |-> carryOut == (maxMin && countIn))
		else $error("carry does not follow the pulse");
	chk_low_time: assert property ($fell(countIn) |-> lowPhase)
		else $error("pulse low phase not five cycles");
	chk_load_time: assert property ($fell(loadN) |-> loadPhase)
		else $error("load low phase not five cycles");
	chk_dir_guard: assert property ($changed(downDir) |-> $past(countIn) ##0 countIn [*5])
		else $error("direction changed near a low phase");
	chk_enable_guard: assert property ($changed(enable) |-> $past(countIn) ##0 countIn [*5])
		else $error("enable changed near a low phase");
endmodule : sudc_link_chk

// *** bench/sync_up_down_counter_bin_bcd_tb.sv ***
// Bench: controller driving a binary stage, plus a BCD stage driven by the bench
module sync_up_down_counter_bin_bcd_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import sudc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] datI = 32'h0000_0000;
	logic [31:0] datO;
	logic [31:0] rd;
	logic [3:0] sel = 4'hF;
	logic we = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic ack;
	logic irq;
	logic binFault;
	logic bcdFault;
	logic binWrap;
	logic bcdWrap;
	int binWraps = 0;
	int bcdWraps = 0;
	int fails = 0;
	int checks = 0;
	sudc_link_if link ();
	sudc_link_if bLink ();
	sudc_link_if hiLink ();
	always #5 clk = ~clk;
	sudc_controller i_sudc_controller (.clk(clk), .rst_n(rst_n), .adr_i(adr), .dat_i(datI), .dat_o(datO),
		.we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .irq(irq), .link(link.ctl));
	sudc_counter #(.BCD_MODE(1'b0)) i_sudc_counter (.clk(clk), .rst_n(rst_n), .link(link.dev),
		.wrapPulse(binWrap), .timingFault(binFault));
	// Upper stage cascaded by look-ahead: the lower flag enables it
	assign hiLink.countIn = link.countIn;
	assign hiLink.enable = link.maxMin;
	assign hiLink.loadN = link.loadN;
	assign hiLink.loadData = link.loadData;
	assign hiLink.downDir = link.downDir;
	sudc_counter #(.BCD_MODE(1'b0)) i_sudc_counter_hi (.clk(clk), .rst_n(rst_n), .link(hiLink.dev),
		.wrapPulse(), .timingFault());
	sudc_counter #(.BCD_MODE(1'b1)) i_sudc_counter_bcd (.clk(clk), .rst_n(rst_n), .link(bLink.dev),
		.wrapPulse(bcdWrap), .timingFault(bcdFault));

	// Wrap pulses last one cycle, so they are tallied at every edge
	always @(posedge clk)
	begin
		if (binWrap === 1'b1)
			binWraps++;
		if (bcdWrap === 1'b1)
			bcdWraps++;
	end
	sudc_link_chk i_sudc_link_chk (.clk(clk), .rst_n(rst_n), .countIn(link.countIn), .enable(link.enable),
		.loadN(link.loadN), .loadData(link.loadData), .downDir(link.downDir), .count(link.count),
		.carryOut(link.carryOut), .maxMin(link.maxMin));

	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// First edge is passed before ack is looked at: the previous ack may still be high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= d;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (ack !== 1'b1 && i < 20);
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			fails++;
			complete_run();
		end
	endtask : wb

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
		wb(1'b0, a, 32'h0000_0000);
		chk(name, exp, rd);
	endtask : rdc

	task automatic idle();
		int i;
		for (i = 0; i < 60; i++)
		begin
			wb(1'b0, REG_STATUS, 32'h0000_0000);
			if (rd[STAT_BUSY_BIT] === 1'b0)
				return;
		end
		fails++;
		complete_run();
	endtask : idle

	task automatic run(input logic [31:0] n);
		wb(1'b1, REG_CMD, n);
		idle();
	endtask : run

	task automatic s_reset();
		rdc(REG_CTRL, 16'h0000, "ctrl");
		rdc(REG_STATUS, 16'h0000, "status");
		wb(1'b1, 8'h18, 32'hFFFF_FFFF);
		rdc(8'h18, 16'h0000, "unmapped");
	endtask : s_reset

	task automatic s_up();
		wb(1'b1, REG_LOAD, 16'h0FFE);
		idle();
		rdc(REG_STATUS, 16'h0FFE, "load");
		wb(1'b1, REG_IRQ_STATUS, 16'h0003);
		wb(1'b1, REG_CTRL, 16'h0001);
		run(16'h0001);
		rdc(REG_STATUS, 16'h1FFF, "top");
		rdc(REG_IRQ_STATUS, 16'h0003, "flags");
		chk("irq masked", 1'h0, irq);
		wb(1'b1, REG_IRQ_MASK, 16'h0001);
		rdc(REG_IRQ_MASK, 16'h0001, "mask");
		chk("irq", 1'h1, irq);
		wb(1'b1, REG_IRQ_STATUS, 16'h0001);
		rdc(REG_IRQ_STATUS, 16'h0002, "cleared");
		run(16'h0001);
		rdc(REG_STATUS, 16'h0000, "wrap");
		chk("upper up", 12'h0FFF, hiLink.count);
		chk("irq off", 1'h0, irq);
	endtask : s_up

	task automatic s_down();
		wb(1'b1, REG_CTRL, 16'h0003);
		rdc(REG_CTRL, 16'h0003, "ctrl");
		rdc(REG_STATUS, 16'h1000, "bottom");
		run(16'h0002);
		rdc(REG_STATUS, 16'h0FFE, "down");
		chk("upper down", 12'h0FFE, hiLink.count);
	endtask : s_down

	task automatic s_hold();
		wb(1'b1, REG_CTRL, 16'h0002);
		run(16'h0003);
		rdc(REG_STATUS, 16'h0FFE, "disabled");
		wb(1'b1, REG_CTRL, 16'h0000);
		rdc(REG_STATUS, 16'h0FFE, "turned");
	endtask : s_hold

	// Reload on reaching zero makes a divide-by-two
	task automatic s_mod();
		wb(1'b1, REG_CTRL, 16'h0007);
		wb(1'b1, REG_LOAD, 16'h0002);
		idle();
		run(16'h0003);
		rdc(REG_STATUS, 16'h0001, "modulo");
	endtask : s_mod

	task automatic bp();
		@(posedge clk);
		bLink.countIn <= 1'b0;
		repeat (5) @(posedge clk);
		bLink.countIn <= 1'b1;
		repeat (5) @(posedge clk);
	endtask : bp

	task automatic bl(input logic [11:0] v);
		@(posedge clk);
		bLink.loadData <= v;
		bLink.loadN <= 1'b0;
		repeat (5) @(posedge clk);
		bLink.loadN <= 1'b1;
		repeat (2) @(posedge clk);
	endtask : bl

	task automatic s_bcd();
		bLink.enable <= 1'b1;
		bl(12'h998);
		bLink.loadData <= 12'h555;
		bp();
		chk("bcd top", 12'h999, bLink.count);
		chk("bcd flag", 1'h1, bLink.maxMin);
		chk("bcd carry", 1'h1, bLink.carryOut);
		bp();
		chk("bcd wrap", 12'h000, bLink.count);
		chk("bcd carry low", 1'h0, bLink.carryOut);
		bLink.downDir <= 1'b1;
		repeat (5) @(posedge clk);
		bp();
		chk("bcd under", 12'h999, bLink.count);
		bl(12'h100);
		bp();
		chk("bcd borrow", 12'h099, bLink.count);
		chk("bin fault", 1'h0, binFault);
		chk("bcd fault clean", 1'h0, bcdFault);
		bLink.countIn <= 1'b0;
		@(posedge clk);
		bLink.downDir <= 1'b0;
		repeat (5) @(posedge clk);
		bLink.countIn <= 1'b1;
		repeat (2) @(posedge clk);
		chk("bcd fault", 1'h1, bcdFault);
		chk("bin wraps", 32'h0000_0002, binWraps);
		chk("bcd wraps", 32'h0000_0002, bcdWraps);
	endtask : s_bcd

	initial
	begin
		bLink.countIn = 1'b1;
		bLink.enable = 1'b0;
		bLink.loadN = 1'b1;
		bLink.downDir = 1'b0;
		bLink.loadData = 12'h000;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		s_reset();
		s_up();
		s_down();
		s_hold();
		s_mod();
		s_bcd();
		complete_run();
	end
endmodule : sync_up_down_counter_bin_bcd_tb
